// ### rtl/pmcbp_pkg.sv
// Package for the management control bus port: sizes, register indices and timing
package pmcbp_pkg;
   localparam int unsigned REG_COUNT = 64;
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 8;
   localparam logic [5:0] IRQ_COND_ADDR = 6'h02;
   localparam logic [5:0] IRQ_MASK_ADDR = 6'h03;
   localparam int unsigned PARITY_ERR_BIT = 0;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
   localparam int unsigned ACCESS_CYCLES = 2;
   typedef enum logic [1:0] {
      PMCBP_IDLE,
      PMCBP_WAIT,
      PMCBP_ACK
   } pmcbp_state_t;
endpackage : pmcbp_pkg

// ### rtl/pmcbp_sync.sv
// Two-flop synchroniser for one asynchronous bus input line
`timescale 1ns/1ps
`default_nettype none
module pmcbp_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic din,
   output logic dout
);
   logic meta_ff;
   logic sync_ff;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta_ff <= RESET_VAL;
         sync_ff <= RESET_VAL;
      end else if (ce) begin
         meta_ff <= din;
         sync_ff <= meta_ff;
      end
   end
   assign dout = sync_ff;
endmodule : pmcbp_sync
`default_nettype wire

// ### rtl/pmcbp_port.sv
// Management control bus port with register file, parity check and interrupt output
`timescale 1ns/1ps
`default_nettype none
module pmcbp_port
   import pmcbp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic sel_n,
   input wire logic rd_wr,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] bus_data_in,
   input wire logic bus_parity_in,
   input wire logic [7:0] irq_event,
   output logic [7:0] bus_data_out,
   output logic bus_parity_out,
   output logic bus_oe_n,
   output logic ack_oe_n,
   output logic irq_oe_n
);
   logic sel_n_s;
   logic rd_wr_s;
   logic [5:0] addr_s;
   logic [7:0] data_s;
   logic parity_s;
   logic [7:0] regs_ff [REG_COUNT];
   logic [7:0] irq_cond_ff;
   logic [7:0] irq_mask_ff;
   pmcbp_state_t state_ff;
   pmcbp_state_t nxt_state;
   logic [1:0] wait_ff;
   logic [1:0] nxt_wait;
   logic [7:0] bus_data_out_ff;
   logic bus_parity_out_ff;
   logic bus_oe_n_ff;
   logic ack_oe_n_ff;
   logic irq_oe_n_ff;

   // Every bus pin is asynchronous to clk_sys
   pmcbp_sync #(.RESET_VAL(1'b1)) u_sel (.clk_sys(clk_sys), .rst(rst), .ce(ce),
      .din(sel_n), .dout(sel_n_s));
   pmcbp_sync #(.RESET_VAL(1'b1)) u_rw (.clk_sys(clk_sys), .rst(rst), .ce(ce),
      .din(rd_wr), .dout(rd_wr_s));
   pmcbp_sync #(.RESET_VAL(1'b0)) u_par (.clk_sys(clk_sys), .rst(rst), .ce(ce),
      .din(bus_parity_in), .dout(parity_s));
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_addr
         pmcbp_sync #(.RESET_VAL(1'b0)) u_a (.clk_sys(clk_sys), .rst(rst), .ce(ce),
            .din(reg_addr[gi]), .dout(addr_s[gi]));
      end
      for (gi = 0; gi < 8; gi++) begin : g_data
         pmcbp_sync #(.RESET_VAL(1'b0)) u_d (.clk_sys(clk_sys), .rst(rst), .ce(ce),
            .din(bus_data_in[gi]), .dout(data_s[gi]));
      end
   endgenerate

   wire wait_done = (wait_ff == 2'(ACCESS_CYCLES - 1));
   wire access = (state_ff == PMCBP_WAIT) && wait_done && !sel_n_s;
   wire is_read = access && rd_wr_s;
   wire is_write = access && !rd_wr_s;
   wire parity_ok = ^{data_s, parity_s};
   wire write_ok = is_write && parity_ok;
   wire parity_bad = is_write && !parity_ok;
   wire hit_cond = (addr_s == IRQ_COND_ADDR);
   wire hit_mask = (addr_s == IRQ_MASK_ADDR);
   wire [7:0] rd_byte = hit_cond ? irq_cond_ff : (hit_mask ? irq_mask_ff : regs_ff[addr_s]);
   wire rd_parity = ~^rd_byte;
   wire [7:0] err_vec = parity_bad ? (8'h01 << PARITY_ERR_BIT) : 8'h00;
   // Writing one clears a condition; new events win over the clear
   wire [7:0] cond_clr = (write_ok && hit_cond) ? data_s : 8'h00;
   wire [7:0] nxt_cond = (irq_cond_ff & ~cond_clr) | irq_event | err_vec;
   // The pin follows the mask as it will stand after this edge
   wire [7:0] nxt_mask = (write_ok && hit_mask) ? data_s : irq_mask_ff;
   wire nxt_irq_n = ~|(nxt_cond & ~nxt_mask);

   always_comb begin
      nxt_state = state_ff;
      nxt_wait = wait_ff;
      case (state_ff)
         PMCBP_IDLE: begin
            nxt_wait = 2'h0;
            if (!sel_n_s) begin
               nxt_state = PMCBP_WAIT;
            end
         end
         PMCBP_WAIT: begin
            if (sel_n_s) begin
               nxt_state = PMCBP_IDLE;
            end else if (wait_done) begin
               nxt_state = PMCBP_ACK;
            end else begin
               nxt_wait = wait_ff + 2'h1;
            end
         end
         PMCBP_ACK: begin
            if (sel_n_s) begin
               nxt_state = PMCBP_IDLE;
            end
         end
         default: nxt_state = PMCBP_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_ff <= PMCBP_IDLE;
         wait_ff <= 2'h0;
      end else if (ce) begin
         state_ff <= nxt_state;
         wait_ff <= nxt_wait;
      end
   end

   // Plain register storage
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         regs_ff <= '{default: REG_RESET};
      end else if (ce && write_ok && !hit_cond && !hit_mask) begin
         regs_ff[addr_s] <= data_s;
      end
   end

   // Interrupt conditions, mask and pin
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_cond_ff <= 8'h00;
         irq_mask_ff <= IRQ_MASK_RESET;
         irq_oe_n_ff <= 1'b1;
      end else if (ce) begin
         irq_cond_ff <= nxt_cond;
         irq_oe_n_ff <= nxt_irq_n;
         if (write_ok && hit_mask) begin
            irq_mask_ff <= data_s;
         end
      end
   end

   // Read data, bus drivers and acknowledge
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bus_data_out_ff <= 8'h00;
         bus_parity_out_ff <= 1'b0;
         bus_oe_n_ff <= 1'b1;
         ack_oe_n_ff <= 1'b1;
      end else if (ce) begin
         if (is_read) begin
            bus_data_out_ff <= rd_byte;
            bus_parity_out_ff <= rd_parity;
            bus_oe_n_ff <= 1'b0;
         end else if (sel_n_s) begin
            bus_oe_n_ff <= 1'b1;
         end
         ack_oe_n_ff <= !(nxt_state == PMCBP_ACK);
      end
   end

   assign bus_data_out = bus_data_out_ff;
   assign bus_parity_out = bus_parity_out_ff;
   assign bus_oe_n = bus_oe_n_ff;
   assign ack_oe_n = ack_oe_n_ff;
   assign irq_oe_n = irq_oe_n_ff;

   a_ack_holds_sel: assert property (@(posedge clk_sys) disable iff (rst)
      ce && !ack_oe_n_ff && !sel_n_s |=> !ack_oe_n_ff)
      else $error("ack released while select low");
   a_ack_needs_sel: assert property (@(posedge clk_sys) disable iff (rst)
      ce && sel_n_s && ack_oe_n_ff |=> ack_oe_n_ff)
      else $error("ack raised without select");
   a_ack_drops_end: assert property (@(posedge clk_sys) disable iff (rst)
      ce && !ack_oe_n_ff && sel_n_s |=> ack_oe_n_ff)
      else $error("ack not released after select high");
   a_read_drive_on: assert property (@(posedge clk_sys) disable iff (rst)
      ce && !ack_oe_n_ff && rd_wr_s && !sel_n_s |-> !bus_oe_n_ff)
      else $error("read data not driven during ack");
   a_read_parity_odd: assert property (@(posedge clk_sys) disable iff (rst)
      !bus_oe_n_ff |-> ^{bus_data_out_ff, bus_parity_out_ff})
      else $error("read parity not odd");
   a_bad_par_flag: assert property (@(posedge clk_sys) disable iff (rst)
      ce && parity_bad |=> irq_cond_ff[PARITY_ERR_BIT])
      else $error("parity error flag not set");
   a_bad_par_keep: assert property (@(posedge clk_sys) disable iff (rst)
      ce && parity_bad && !hit_cond && !hit_mask |=> regs_ff[$past(addr_s)] == $past(rd_byte))
      else $error("register written despite bad parity");
   a_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
      ce |=> irq_oe_n_ff == ~|(irq_cond_ff & ~irq_mask_ff))
      else $error("interrupt pin does not match masked conditions");
   a_bus_off_idle: assert property (@(posedge clk_sys) disable iff (rst)
      ce && sel_n_s |=> bus_oe_n_ff)
      else $error("bus driven with select high");
   a_write_stores: assert property (@(posedge clk_sys) disable iff (rst)
      ce && write_ok && !hit_cond && !hit_mask |=> regs_ff[$past(addr_s)] == $past(data_s))
      else $error("good write not stored");
   a_ack_on_access: assert property (@(posedge clk_sys) disable iff (rst)
      ce && access |=> !ack_oe_n_ff)
      else $error("no acknowledge after access");
   a_bus_off_write: assert property (@(posedge clk_sys) disable iff (rst)
      ce && is_write |=> bus_oe_n_ff)
      else $error("bus driven during write");
   c_read: cover property (@(posedge clk_sys) disable iff (rst) ce && is_read);
   c_write: cover property (@(posedge clk_sys) disable iff (rst) ce && write_ok);
   c_bad_parity: cover property (@(posedge clk_sys) disable iff (rst) ce && parity_bad);
   c_irq: cover property (@(posedge clk_sys) disable iff (rst) !irq_oe_n_ff);
   c_ack_release: cover property (@(posedge clk_sys) disable iff (rst)
      ce && !ack_oe_n_ff && sel_n_s);
endmodule : pmcbp_port
`default_nettype wire

// ### bench/pmcbp_ctrl.sv
// Management controller model that runs cycles on the port
`timescale 1ns/1ps
`default_nettype none
module pmcbp_ctrl (
   input wire logic clk_sys,
   input wire logic ack_n,
   input wire logic [7:0] bus_data,
   input wire logic bus_parity,
   output logic sel_n,
   output logic rd_wr,
   output logic [5:0] reg_addr,
   output logic [7:0] drv_data,
   output logic drv_par
);
   int hold_err = 0;
   initial begin
      sel_n = 1'b1;
      rd_wr = 1'b1;
      reg_addr = 6'h00;
      drv_data = 8'h00;
      drv_par = 1'b1;
   end
   task automatic cyc(input logic rd, input logic [5:0] a, input logic [7:0] d,
         input logic bad, output logic [7:0] q, output logic qp);
      int n;
      n = 0;
      @(negedge clk_sys);
      rd_wr = rd;
      reg_addr = a;
      drv_data = d;
      drv_par = ~^d ^ bad;
      sel_n = 1'b0;
      while (ack_n !== 1'b0 && n < 20) begin
         @(posedge clk_sys);
         #1 n++;
      end
      q = bus_data;
      qp = bus_parity;
      repeat ($urandom_range(3, 0)) @(posedge clk_sys);
      #1 hold_err += int'(ack_n !== 1'b0);
      @(negedge clk_sys);
      sel_n = 1'b1;
      drv_data = ~drv_data;
      drv_par = ~drv_par;
      n = 0;
      while (ack_n !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         #1 n++;
      end
      hold_err += int'(ack_n !== 1'b1);
   endtask : cyc
endmodule : pmcbp_ctrl
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the management port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pmcbp_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] irq_event = 8'h00;
   logic ce = 1'b1;
   wire logic sel_n, rd_wr, drv_par, bus_parity_out, bus_oe_n, ack_oe_n, irq_oe_n;
   wire logic [5:0] reg_addr;
   wire logic [7:0] drv_data, bus_data_out;
   wire logic [7:0] bus_data = bus_oe_n ? drv_data : bus_data_out;
   wire logic bus_parity = bus_oe_n ? drv_par : bus_parity_out;
   int n_mismatch = 0;
   int compares = 0;
   int mem[64];
   int cond = 0;
   int mask = 0;
   logic [7:0] q;
   logic qp;
   logic [5:0] a;
   logic [7:0] d;
   always #20 clk_sys = ~clk_sys;
   pmcbp_port uut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .sel_n(sel_n), .rd_wr(rd_wr),
      .reg_addr(reg_addr), .bus_data_in(bus_data), .bus_parity_in(bus_parity),
      .irq_event(irq_event), .bus_data_out(bus_data_out), .bus_parity_out(bus_parity_out),
      .bus_oe_n(bus_oe_n), .ack_oe_n(ack_oe_n), .irq_oe_n(irq_oe_n));
   pmcbp_ctrl ctl (.clk_sys(clk_sys), .ack_n(ack_oe_n), .bus_data(bus_data),
      .bus_parity(bus_parity), .sel_n(sel_n), .rd_wr(rd_wr), .reg_addr(reg_addr),
      .drv_data(drv_data), .drv_par(drv_par));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [5:0] wa, input logic [7:0] wd, input logic bad);
      ctl.cyc(1'b0, wa, wd, bad, q, qp);
      chk("oe on write", 8'h01, {7'h00, bus_oe_n});
      if (bad) cond |= 1;
      else if (wa == IRQ_COND_ADDR) cond &= ~int'(wd);
      else if (wa == IRQ_MASK_ADDR) mask = wd;
      else mem[wa] = wd;
   endtask : wr
   task automatic rd(input logic [5:0] ra);
      logic [7:0] e;
      e = 8'(ra == IRQ_COND_ADDR ? cond : ra == IRQ_MASK_ADDR ? mask : mem[ra]);
      ctl.cyc(1'b1, ra, 8'h00, 1'b0, q, qp);
      chk("read data", e, q);
      chk("read parity", {7'h00, ~^e}, {7'h00, qp});
   endtask : rd
   task automatic irq_chk;
      chk("irq", {7'h00, (cond & ~mask & 255) == 0}, {7'h00, irq_oe_n});
   endtask : irq_chk
   task automatic summarize;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize
   initial begin
      #1_000_000;
      n_mismatch++;
      summarize();
   end
   initial begin
      void'($urandom(9));
      for (int i = 0; i < 64; i++) mem[i] = 0;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys) rst = 1'b0;
      chk("oe after reset", 8'h07, {5'h00, bus_oe_n, ack_oe_n, irq_oe_n});
      for (int i = 0; i < 64; i++) rd(6'(i));
      for (int i = 0; i < 24; i++) begin
         a = (i < 2) ? 6'(i * 63) : 6'($urandom_range(63, 4));
         d = 8'($urandom);
         wr(a, d, 1'b0);
         rd(a);
      end
      wr(6'h05, 8'h3c, 1'b1);
      rd(6'h05);
      rd(IRQ_COND_ADDR);
      irq_chk();
      wr(IRQ_MASK_ADDR, 8'h01, 1'b0);
      irq_chk();
      rd(IRQ_MASK_ADDR);
      @(negedge clk_sys) irq_event = 8'h20;
      @(negedge clk_sys) irq_event = 8'h00;
      cond |= 8'h20;
      repeat (2) @(negedge clk_sys);
      irq_chk();
      rd(IRQ_COND_ADDR);
      wr(IRQ_COND_ADDR, 8'h21, 1'b0);
      irq_chk();
      wr(IRQ_MASK_ADDR, 8'h00, 1'b0);
      irq_chk();
      // An event while the clock enable is low must be lost
      @(negedge clk_sys) ce = 1'b0;
      irq_event = 8'h40;
      @(negedge clk_sys) irq_event = 8'h00;
      @(negedge clk_sys) ce = 1'b1;
      irq_chk();
      rd(IRQ_COND_ADDR);
      repeat (10) @(negedge clk_sys);
      chk("idle oe", 8'h03, {6'h00, bus_oe_n, ack_oe_n});
      chk("ack hold", 8'h00, 8'(ctl.hold_err));
      summarize();
   end
endmodule : tb_top
`default_nettype wire
